/* File: hdl/bsisp_map.vh */
// Constants for the boundary-scan and programming test port.
// Included by every design file of the block; holds definitions only.
`ifndef BSISP_MAP_VH
`define BSISP_MAP_VH

// Test access port controller states
`define BSISP_ST_RESET 4'h0
`define BSISP_ST_IDLE 4'h1
`define BSISP_ST_SEL_DR 4'h2
`define BSISP_ST_CAP_DR 4'h3
`define BSISP_ST_SH_DR 4'h4
`define BSISP_ST_EX1_DR 4'h5
`define BSISP_ST_PA_DR 4'h6
`define BSISP_ST_EX2_DR 4'h7
`define BSISP_ST_UP_DR 4'h8
`define BSISP_ST_SEL_IR 4'h9
`define BSISP_ST_CAP_IR 4'hA
`define BSISP_ST_SH_IR 4'hB
`define BSISP_ST_EX1_IR 4'hC
`define BSISP_ST_PA_IR 4'hD
`define BSISP_ST_EX2_IR 4'hE
`define BSISP_ST_UP_IR 4'hF

// Instruction register
`define BSISP_IR_LEN 4
`define BSISP_IR_EXTEST 4'h0
`define BSISP_IR_IDCODE 4'h1
`define BSISP_IR_SAMPLE 4'h2
`define BSISP_IR_HIGHZ 4'h3
`define BSISP_IR_BYPASS 4'hF
`define BSISP_IR_CAPTURE 4'h1

// Identification register
`define BSISP_ID_LEN 32

// Positions of the four test port pins in the pin vectors
`define BSISP_PIN_TDI 0
`define BSISP_PIN_TMS 1
`define BSISP_PIN_TCK 2
`define BSISP_PIN_TDO 3

// Boundary cell capture stage positions
`define BSISP_CAP_IN 0
`define BSISP_CAP_DATA 1
`define BSISP_CAP_OE 2

`endif

/* File: hdl/bsisp_pin_cell.v */
// Boundary cell for one input or I/O pin: three capture stages, two update stages.
// Control pulses come from the test port controller on the same clock; pad_in is
// already synchronised by the caller.
`timescale 1ns/1ps
`include "bsisp_map.vh"

module bsisp_pin_cell #(
    parameter HAS_OUT = 1
)(
    input wire mclk,
    input wire reset_n,
    input wire capture,
    input wire shift,
    input wire update,
    input wire extest,
    input wire highz,
    input wire scan_in,
    output wire scan_out,
    input wire pad_in,
    input wire core_out,
    input wire core_oe,
    output reg pad_out,
    output reg pad_oe
);

reg [2:0] cap_q;
reg [1:0] upd_q;
wire drv_out;
wire drv_oe;

////////////////////////////////////////////////////////////////////////////////
// Capture stages double as the serial chain
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        cap_q <= 3'h0;
    else if (capture)
        cap_q <= {core_oe, core_out, pad_in}; // [R7]
    else if (shift)
        cap_q <= {cap_q[1:0], scan_in}; // [R6]
end

assign scan_out = cap_q[`BSISP_CAP_OE];

// Update stages hold still while shifting, so the pins do not ripple
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        upd_q <= 2'h0;
    else if (update)
        upd_q <= cap_q[`BSISP_CAP_OE:`BSISP_CAP_DATA]; // [R4]
end

////////////////////////////////////////////////////////////////////////////////
// Pad drive; input-only pins never drive
assign drv_out = extest ? upd_q[0] : core_out; // [R13]
assign drv_oe = highz ? 1'b0 : (extest ? upd_q[1] : core_oe); // [R12]

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        pad_out <= 1'b0;
        pad_oe <= 1'b0;
    end
    else
    begin
        pad_out <= (HAS_OUT != 0) & drv_out;
        pad_oe <= (HAS_OUT != 0) & drv_oe;
    end
end

endmodule // bsisp_pin_cell

/* File: hdl/bsisp_mc_cell.v */
// Boundary cell for one macrocell: captures data, enable and feedback, and in
// external test replaces the feedback into the array from its update stage.
// All inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "bsisp_map.vh"

module bsisp_mc_cell (
    input wire mclk,
    input wire reset_n,
    input wire capture,
    input wire shift,
    input wire update,
    input wire extest,
    input wire scan_in,
    output wire scan_out,
    input wire mc_data,
    input wire mc_oe,
    input wire mc_fb,
    output reg fb_out
);

reg [2:0] cap_q;
reg upd_q;

////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        cap_q <= 3'h0;
    else if (capture)
        cap_q <= {mc_oe, mc_data, mc_fb}; // [R7]
    else if (shift)
        cap_q <= {cap_q[1:0], scan_in}; // [R6]
end

assign scan_out = cap_q[2];

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        upd_q <= 1'b0;
    else if (update)
        upd_q <= cap_q[0]; // [R4]
end

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        fb_out <= 1'b0;
    else
        fb_out <= extest ? upd_q : mc_fb; // [R5]
end

endmodule // bsisp_mc_cell

/* File: hdl/bsisp_top.v */
// Boundary-scan and in-system-programming test port of a programmable logic device.
// Assumes mclk well above the test clock (8x or more); the four test port pins and
// all user pins arrive asynchronously, core and macrocell signals on mclk.
`timescale 1ns/1ps
`include "bsisp_map.vh"

// Functional notes
// [R1] No test-reset pin; controller resets itself at power-up.
// [R2] Five instructions: sample/preload, extest, bypass, idcode, highz.
// [R3] Every input and I/O pin has a boundary cell; 68 I/O, four inputs.
// [R4] Each cell has three capture stages and up to two update stages.
// [R5] Two cell structures: one for pins, one for macrocells.
// [R6] All cells chained through capture stages from test data in to out.
// [R7] Capture stages sample live signals, shift, and load update stages.
// [R8] Capture, shift and update controls come from the port controller.
// [R9] Port is a configuration option; disabled, its four pins are user I/O.
// [R10] Programming runs over the four pins with the standard protocol.
// [R11] A design option enables pull-ups on mode-select and data-in pins.
// [R12] Bypass puts one bit between data pins; highz floats all user outputs.
// [R13] Extest drives pins from update stages; sample leaves function undisturbed.
module bsisp_top #(
    parameter N_IO = 68,
    parameter N_IN = 4,
    parameter N_MC = 64,
    parameter [31:0] IDCODE_VAL = 32'h0ABC_D001 // Arbitrary value, bit 0 set
)(
    input wire mclk,
    input wire reset_n,
    input wire cfg_jtag_en,
    input wire cfg_pullup_en,
    input wire [3:0] tap_pin_in,
    output wire [3:0] tap_pin_out,
    output wire [3:0] tap_pin_oe,
    output wire [1:0] tap_pullup_en,
    input wire [3:0] core_tap_out,
    input wire [3:0] core_tap_oe,
    output wire [3:0] core_tap_in,
    input wire [N_IO+N_IN-1:0] pin_in,
    output wire [N_IO+N_IN-1:0] pin_out,
    output wire [N_IO+N_IN-1:0] pin_oe,
    input wire [N_IO+N_IN-1:0] core_out,
    input wire [N_IO+N_IN-1:0] core_oe,
    output wire [N_IO+N_IN-1:0] core_in,
    input wire [N_MC-1:0] mc_data,
    input wire [N_MC-1:0] mc_oe,
    input wire [N_MC-1:0] mc_fb,
    output wire [N_MC-1:0] mc_fb_out,
    output wire [3:0] isp_tap_state,
    output wire [`BSISP_IR_LEN-1:0] isp_ir
);

localparam N_PIN = N_IO + N_IN;
localparam N_CELL = N_PIN + N_MC;

reg [3:0] tap_s1_q;
reg [3:0] tap_s2_q;
reg tck_prev_q;
reg [2:0] warm_q;
reg [N_PIN-1:0] pin_s1_q;
reg [N_PIN-1:0] pin_s2_q;
reg en_q;
reg pu_q;
reg strap_done_q;
reg [3:0] st_q;
reg [3:0] st_d;
reg [`BSISP_IR_LEN-1:0] ir_sh_q;
reg [`BSISP_IR_LEN-1:0] ir_q;
reg byp_q;
reg [`BSISP_ID_LEN-1:0] id_q;
reg tdo_q;
reg tdo_oe_q;
reg dr_bit;

wire tdi;
wire tms;
wire tck_rise;
wire tck_fall;
wire is_extest;
wire is_sample;
wire is_idcode;
wire is_highz;
wire is_bypass;
wire bsr_sel;
wire bs_capture;
wire bs_shift;
wire bs_update;
wire [N_CELL:0] chain;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; the first stage feeds only the second
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        tap_s1_q <= 4'h0;
        tap_s2_q <= 4'h0;
        pin_s1_q <= {N_PIN{1'b0}};
        pin_s2_q <= {N_PIN{1'b0}};
        tck_prev_q <= 1'b0;
        warm_q <= 3'h0;
    end
    else
    begin
        tap_s1_q <= tap_pin_in; // [R10]
        tap_s2_q <= tap_s1_q;
        pin_s1_q <= pin_in;
        pin_s2_q <= pin_s1_q;
        tck_prev_q <= tap_s2_q[`BSISP_PIN_TCK];
        warm_q <= {warm_q[1:0], 1'b1};
    end
end

assign tdi = tap_s2_q[`BSISP_PIN_TDI];
assign tms = tap_s2_q[`BSISP_PIN_TMS];
// Data and clock share the same sync depth, so setup at the pin is kept
// Reset values of the sync flops are not the pin level; ignore edges until they refill
assign tck_rise = en_q & warm_q[2] & tap_s2_q[`BSISP_PIN_TCK] & ~tck_prev_q;
assign tck_fall = en_q & warm_q[2] & ~tap_s2_q[`BSISP_PIN_TCK] & tck_prev_q;
assign core_in = pin_s2_q;

////////////////////////////////////////////////////////////////////////////////
// Configuration options, caught once after reset release
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        en_q <= 1'b0;
        pu_q <= 1'b0;
        strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
        en_q <= cfg_jtag_en; // [R9]
        pu_q <= cfg_pullup_en;
        strap_done_q <= 1'b1;
    end
end

assign tap_pullup_en = {2{pu_q & en_q}}; // [R11]

// Disabled port hands all four pins to the user logic
assign tap_pin_out = en_q ? {tdo_q, 3'h0} : core_tap_out; // [R9]
assign tap_pin_oe = en_q ? {tdo_oe_q, 3'h0} : core_tap_oe; // [R9]
assign core_tap_in = en_q ? 4'h0 : tap_s2_q;

////////////////////////////////////////////////////////////////////////////////
// Port controller; power-up reset stands in for the missing reset pin
always @*
begin
    st_d = st_q;
    case (st_q)
        `BSISP_ST_RESET: st_d = tms ? `BSISP_ST_RESET : `BSISP_ST_IDLE;
        `BSISP_ST_IDLE: st_d = tms ? `BSISP_ST_SEL_DR : `BSISP_ST_IDLE;
        `BSISP_ST_SEL_DR: st_d = tms ? `BSISP_ST_SEL_IR : `BSISP_ST_CAP_DR;
        `BSISP_ST_CAP_DR: st_d = tms ? `BSISP_ST_EX1_DR : `BSISP_ST_SH_DR;
        `BSISP_ST_SH_DR: st_d = tms ? `BSISP_ST_EX1_DR : `BSISP_ST_SH_DR;
        `BSISP_ST_EX1_DR: st_d = tms ? `BSISP_ST_UP_DR : `BSISP_ST_PA_DR;
        `BSISP_ST_PA_DR: st_d = tms ? `BSISP_ST_EX2_DR : `BSISP_ST_PA_DR;
        `BSISP_ST_EX2_DR: st_d = tms ? `BSISP_ST_UP_DR : `BSISP_ST_SH_DR;
        `BSISP_ST_UP_DR: st_d = tms ? `BSISP_ST_SEL_DR : `BSISP_ST_IDLE;
        `BSISP_ST_SEL_IR: st_d = tms ? `BSISP_ST_RESET : `BSISP_ST_CAP_IR;
        `BSISP_ST_CAP_IR: st_d = tms ? `BSISP_ST_EX1_IR : `BSISP_ST_SH_IR;
        `BSISP_ST_SH_IR: st_d = tms ? `BSISP_ST_EX1_IR : `BSISP_ST_SH_IR;
        `BSISP_ST_EX1_IR: st_d = tms ? `BSISP_ST_UP_IR : `BSISP_ST_PA_IR;
        `BSISP_ST_PA_IR: st_d = tms ? `BSISP_ST_EX2_IR : `BSISP_ST_PA_IR;
        `BSISP_ST_EX2_IR: st_d = tms ? `BSISP_ST_UP_IR : `BSISP_ST_SH_IR;
        `BSISP_ST_UP_IR: st_d = tms ? `BSISP_ST_SEL_DR : `BSISP_ST_IDLE;
        default: st_d = `BSISP_ST_RESET;
    endcase
end

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        st_q <= `BSISP_ST_RESET; // [R1]
    else if (!en_q)
        st_q <= `BSISP_ST_RESET;
    else if (tck_rise)
        st_q <= st_d;
end

assign isp_tap_state = st_q; // [R10]
assign isp_ir = ir_q;

////////////////////////////////////////////////////////////////////////////////
// Instruction register; takes effect on the falling test clock in update-IR
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        ir_sh_q <= `BSISP_IR_CAPTURE;
        ir_q <= `BSISP_IR_IDCODE;
    end
    else if (st_q == `BSISP_ST_RESET)
        ir_q <= `BSISP_IR_IDCODE;
    else if (tck_rise && st_q == `BSISP_ST_CAP_IR)
        ir_sh_q <= `BSISP_IR_CAPTURE;
    else if (tck_rise && st_q == `BSISP_ST_SH_IR)
        ir_sh_q <= {tdi, ir_sh_q[`BSISP_IR_LEN-1:1]};
    else if (tck_fall && st_q == `BSISP_ST_UP_IR)
        ir_q <= ir_sh_q;
end

// Unassigned codes fall back to bypass so the chain length stays defined
assign is_extest = (ir_q == `BSISP_IR_EXTEST); // [R2]
assign is_sample = (ir_q == `BSISP_IR_SAMPLE); // [R2]
assign is_idcode = (ir_q == `BSISP_IR_IDCODE); // [R2]
assign is_highz = (ir_q == `BSISP_IR_HIGHZ); // [R2]
assign is_bypass = ~(is_extest | is_sample | is_idcode); // [R2]
assign bsr_sel = is_extest | is_sample;

////////////////////////////////////////////////////////////////////////////////
// Boundary control pulses, one mclk cycle each
assign bs_capture = bsr_sel & tck_rise & (st_q == `BSISP_ST_CAP_DR); // [R8]
assign bs_shift = bsr_sel & tck_rise & (st_q == `BSISP_ST_SH_DR); // [R8]
assign bs_update = bsr_sel & tck_fall & (st_q == `BSISP_ST_UP_DR); // [R8]

////////////////////////////////////////////////////////////////////////////////
// Bypass and identification registers
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        byp_q <= 1'b0;
        id_q <= {`BSISP_ID_LEN{1'b0}};
    end
    else if (tck_rise && st_q == `BSISP_ST_CAP_DR)
    begin
        byp_q <= 1'b0;
        id_q <= IDCODE_VAL;
    end
    else if (tck_rise && st_q == `BSISP_ST_SH_DR)
    begin
        byp_q <= tdi; // [R12]
        id_q <= {tdi, id_q[`BSISP_ID_LEN-1:1]};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Boundary chain: pin cells first, then macrocell cells
assign chain[0] = tdi; // [R6]

genvar gi;
generate
    for (gi = 0; gi < N_PIN; gi = gi + 1)
    begin : g_pin
        bsisp_pin_cell #(
            .HAS_OUT((gi < N_IO) ? 1 : 0)
        ) u_cell (
            .mclk(mclk),
            .reset_n(reset_n),
            .capture(bs_capture),
            .shift(bs_shift),
            .update(bs_update),
            .extest(is_extest),
            .highz(is_highz),
            .scan_in(chain[gi]),
            .scan_out(chain[gi+1]),
            .pad_in(pin_s2_q[gi]),
            .core_out(core_out[gi]),
            .core_oe(core_oe[gi]),
            .pad_out(pin_out[gi]),
            .pad_oe(pin_oe[gi])
        ); // [R3]
    end
    for (gi = 0; gi < N_MC; gi = gi + 1)
    begin : g_mc
        bsisp_mc_cell u_cell (
            .mclk(mclk),
            .reset_n(reset_n),
            .capture(bs_capture),
            .shift(bs_shift),
            .update(bs_update),
            .extest(is_extest),
            .scan_in(chain[N_PIN+gi]),
            .scan_out(chain[N_PIN+gi+1]),
            .mc_data(mc_data[gi]),
            .mc_oe(mc_oe[gi]),
            .mc_fb(mc_fb[gi]),
            .fb_out(mc_fb_out[gi])
        ); // [R5]
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Test data out changes on the falling test clock, driven only while shifting
always @*
begin
    dr_bit = byp_q;
    if (bsr_sel)
        dr_bit = chain[N_CELL]; // [R6]
    else if (is_idcode)
        dr_bit = id_q[0];
    else if (is_bypass || is_highz)
        dr_bit = byp_q; // [R12]
end

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        tdo_q <= 1'b0;
        tdo_oe_q <= 1'b0;
    end
    else if (!en_q)
    begin
        tdo_q <= 1'b0;
        tdo_oe_q <= 1'b0;
    end
    else if (tck_fall)
    begin
        if (st_q == `BSISP_ST_SH_DR)
        begin
            tdo_q <= dr_bit;
            tdo_oe_q <= 1'b1;
        end
        else if (st_q == `BSISP_ST_SH_IR)
        begin
            tdo_q <= ir_sh_q[0];
            tdo_oe_q <= 1'b1;
        end
        else
            tdo_oe_q <= 1'b0;
    end
end

endmodule // bsisp_top

/* File: bench/bsisp_chk.sv */
// Checker for the test port: pad, feedback and port-pin relations over time.
// Sees only the top module's ports; bound to every instance of it.
`timescale 1ns/1ps
`include "bsisp_map.vh"

module bsisp_chk #(
    parameter N_IO = 68,
    parameter N_IN = 4,
    parameter N_MC = 64
)(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cfg_jtag_en,
    input wire logic cfg_pullup_en,
    input wire logic [3:0] tap_pin_in,
    input wire logic [3:0] tap_pin_out,
    input wire logic [3:0] tap_pin_oe,
    input wire logic [1:0] tap_pullup_en,
    input wire logic [3:0] core_tap_out,
    input wire logic [3:0] core_tap_oe,
    input wire logic [3:0] core_tap_in,
    input wire logic [N_IO+N_IN-1:0] pin_out,
    input wire logic [N_IO+N_IN-1:0] pin_oe,
    input wire logic [N_IO+N_IN-1:0] core_out,
    input wire logic [N_IO+N_IN-1:0] core_oe,
    input wire logic [N_MC-1:0] mc_fb,
    input wire logic [N_MC-1:0] mc_fb_out,
    input wire logic [3:0] isp_tap_state,
    input wire logic [3:0] isp_ir
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // Three settled cycles cover any pad register latency
    sequence sample_s;
        (isp_ir == `BSISP_IR_SAMPLE && $stable(core_out) && $stable(core_oe)
            && $stable(mc_fb))[*3];
    endsequence
    sequence tck_rise_idle_s;
        $rose(tap_pin_in[`BSISP_PIN_TCK]) && tap_pin_in[`BSISP_PIN_TMS]
            && isp_tap_state == `BSISP_ST_IDLE;
    endsequence
    ////////////////////////////////////////
    idle_exit_a: assert property (tck_rise_idle_s |-> ##[1:4] isp_tap_state == `BSISP_ST_SEL_DR)
        else $error("controller missed a test clock edge");
    // The strap is caught a cycle after reset release; until then the pins are user I/O
    tdo_drive_a: assert property (cfg_jtag_en[*3] ##0 tap_pin_oe[3] |-> isp_tap_state inside
        {`BSISP_ST_SH_DR, `BSISP_ST_EX1_DR, `BSISP_ST_SH_IR, `BSISP_ST_EX1_IR})
        else $error("data output driven outside a shift");
    ir_update_a: assert property ($changed(isp_ir) |->
        isp_tap_state inside {`BSISP_ST_UP_IR, `BSISP_ST_RESET})
        else $error("instruction changed outside update");
    highz_float_a: assert property ((isp_ir == `BSISP_IR_HIGHZ)[*3] |-> pin_oe == '0)
        else $error("pad enabled while floating");
    sample_pass_a: assert property (sample_s |-> pin_out[N_IO-1:0] == core_out[N_IO-1:0]
        && pin_oe[N_IO-1:0] == core_oe[N_IO-1:0] && mc_fb_out == mc_fb)
        else $error("sampling disturbed the pads");
    input_only_a: assert property (pin_out[N_IO+N_IN-1:N_IO] == '0
        && pin_oe[N_IO+N_IN-1:N_IO] == '0)
        else $error("input-only pin driven");
    user_pins_a: assert property ((!cfg_jtag_en)[*3] |-> tap_pin_out == core_tap_out
        && tap_pin_oe == core_tap_oe && tap_pullup_en == 2'h0)
        else $error("port pins not handed to user logic");
    port_pins_a: assert property (cfg_jtag_en[*4] |-> tap_pin_oe[2:0] == 3'h0
        && core_tap_in == 4'h0)
        else $error("port pins leak to user logic");
    pullup_on_a: assert property ((cfg_jtag_en && cfg_pullup_en)[*4] |-> tap_pullup_en == 2'h3)
        else $error("pull-ups not enabled");
endmodule // bsisp_chk

bind bsisp_top bsisp_chk #(.N_IO(N_IO), .N_IN(N_IN), .N_MC(N_MC)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .cfg_jtag_en(cfg_jtag_en), .cfg_pullup_en(cfg_pullup_en),
    .tap_pin_in(tap_pin_in), .tap_pin_out(tap_pin_out), .tap_pin_oe(tap_pin_oe),
    .tap_pullup_en(tap_pullup_en), .core_tap_out(core_tap_out), .core_tap_oe(core_tap_oe),
    .core_tap_in(core_tap_in), .pin_out(pin_out), .pin_oe(pin_oe), .core_out(core_out),
    .core_oe(core_oe), .mc_fb(mc_fb), .mc_fb_out(mc_fb_out), .isp_tap_state(isp_tap_state),
    .isp_ir(isp_ir)
);

/* File: bench/bsisp_host.sv */
// Test-port host model: drives clock, mode and data lines and samples data out.
// Assumes mclk runs eight times the test clock; all changes land on mclk edges.
`timescale 1ns/1ps

module bsisp_host (
    input wire logic mclk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial
    begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end
    ////////////////////////////////////////
    // Low five, high three: data out settles up to four cycles after the fall
    task automatic slot(input logic m, input logic d, output logic o);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge mclk);
        @(negedge mclk) o = tdo;
        @(posedge mclk) tck <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    // From idle: scan n bits LSB first, back to idle; clock stands high after
    task automatic scan(input logic ir, input int n, input logic [407:0] din,
        output logic [407:0] dout);
        logic x;
        dout = '0;
        slot(1'b1, 1'b0, x);
        if (ir)
            slot(1'b1, 1'b0, x);
        slot(1'b0, 1'b0, x);
        slot(1'b0, 1'b0, x);
        for (int i = 0; i < n; i++)
            slot(i == n - 1, din[i], dout[i]);
        slot(1'b1, 1'b0, x);
        slot(1'b0, 1'b0, x);
    endtask
endmodule // bsisp_host

/* File: bench/testbench.sv */
// Self-checking bench for the test port: host model on the four pins,
// live pad and macrocell values held constant while scanned.
`timescale 1ns/1ps
`include "bsisp_map.vh"

module testbench;
    localparam [31:0] ID = 32'h1234_5671; // Arbitrary value, bit 0 set
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cfg_jtag_en = 1'b1;
    logic cfg_pullup_en = 1'b1;
    logic [3:0] core_tap_out = 4'h5;
    logic [3:0] core_tap_oe = 4'hA;
    logic [71:0] pin_in = 72'hC3_5A96_0FF0_1234_ABCD;
    logic [71:0] core_out = 72'h0D_9C3A_55AA_E71B_0F63;
    logic [71:0] core_oe = 72'h0B_F00F_3C3C_1E2D_A596;
    logic [63:0] mc_data = 64'h1234_5678_9ABC_DEF0;
    logic [63:0] mc_oe = 64'hF0F0_0F0F_AA55_33CC;
    logic [63:0] mc_fb = 64'h0FED_CBA9_8765_4321;
    logic tck, tms, tdi;
    wire [3:0] tap_pin_out, tap_pin_oe, core_tap_in, isp_tap_state, isp_ir;
    wire [1:0] tap_pullup_en;
    wire [71:0] pin_out, pin_oe, core_in;
    wire [63:0] mc_fb_out;
    // Released data-out pin floats to its pull-up
    wire [3:0] tap_pin_in = {tap_pin_oe[3] ? tap_pin_out[3] : 1'b1, tck, tms, tdi};
    int n_fail = 0;
    int cmp_count = 0;
    logic [407:0] so, pre;

    always #50 mclk = ~mclk;

    bsisp_top #(.IDCODE_VAL(ID)) DUT (
        .mclk(mclk), .reset_n(reset_n), .cfg_jtag_en(cfg_jtag_en),
        .cfg_pullup_en(cfg_pullup_en), .tap_pin_in(tap_pin_in), .tap_pin_out(tap_pin_out),
        .tap_pin_oe(tap_pin_oe), .tap_pullup_en(tap_pullup_en), .core_tap_out(core_tap_out),
        .core_tap_oe(core_tap_oe), .core_tap_in(core_tap_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .core_out(core_out), .core_oe(core_oe),
        .core_in(core_in), .mc_data(mc_data), .mc_oe(mc_oe), .mc_fb(mc_fb),
        .mc_fb_out(mc_fb_out), .isp_tap_state(isp_tap_state), .isp_ir(isp_ir)
    );
    bsisp_host host (.mclk(mclk), .tdo(tap_pin_in[3]), .tck(tck), .tms(tms), .tdi(tdi));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [407:0] exp, input logic [407:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Options are straps, so they only change under reset
    task automatic do_reset(input logic en);
        reset_n <= 1'b0;
        cfg_jtag_en <= en;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("state", `BSISP_ST_RESET, isp_tap_state);
        chk("ir", `BSISP_IR_IDCODE, isp_ir);
    endtask

    task automatic ld(input logic [3:0] c);
        host.scan(1'b1, 4, {404'h0, c}, so);
        chk("ir capture", 4'h1, so[3:0]);
    endtask
    ////////////////////////////////////////
    task automatic t_idcode();
        logic x;
        host.slot(1'b0, 1'b0, x);
        host.scan(1'b0, 32, '0, so);
        chk("idcode", ID, so[31:0]);
        chk("pullups", 2'h3, tap_pullup_en);
    endtask

    task automatic t_codes();
        logic [3:0] c[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF, 4'h7};
        foreach (c[i])
        begin
            ld(c[i]);
            repeat (4) @(posedge mclk);
            if (i < 5)
                chk("active code", c[i], isp_ir);
            if (c[i] == `BSISP_IR_HIGHZ)
                chk("highz enables", 72'h0, pin_oe);
            if (i > 3)
            begin
                host.scan(1'b0, 8, 408'hB4, so);
                chk("bypass", 8'h68, so[7:0]);
            end
        end
    endtask

    // Chain out-order: bit i leaves from position 407-i counted from data in
    task automatic t_sample();
        logic [407:0] e;
        ld(`BSISP_IR_SAMPLE);
        for (int q = 0; q < 408; q++)
            pre[407-q] = q[0] ^ q[2];
        for (int k = 0; k < 136; k++)
        begin
            e[407-3*k] = k < 72 ? pin_in[k] : mc_fb[k-72];
            e[406-3*k] = k < 72 ? core_out[k] : mc_data[k-72];
            e[405-3*k] = k < 72 ? core_oe[k] : mc_oe[k-72];
        end
        host.scan(1'b0, 408, pre, so);
        chk("sampled chain", e, so);
        chk("pads in sample", core_out, pin_out);
        chk("core in", pin_in, core_in);
    endtask

    task automatic t_extest();
        logic [71:0] eo = '0;
        logic [71:0] ee = '0;
        logic [63:0] ef;
        for (int k = 0; k < 68; k++)
        begin
            eo[k] = pre[406-3*k];
            ee[k] = pre[405-3*k];
            if (k < 64)
                ef[k] = pre[191-3*k];
        end
        ld(`BSISP_IR_EXTEST);
        repeat (4) @(posedge mclk);
        chk("extest pad out", eo, pin_out);
        chk("extest pad oe", ee, pin_oe);
        chk("extest feedback", ef, mc_fb_out);
    endtask

    task automatic t_user_pins();
        do_reset(1'b0);
        chk("pin drive", core_tap_out, tap_pin_out);
        chk("pin enable", core_tap_oe, tap_pin_oe);
        chk("pins to core", tap_pin_in, core_tap_in);
        chk("pullups off", 2'h0, tap_pullup_en);
    endtask
    ////////////////////////////////////////
    initial
    begin
        do_reset(1'b1);
        t_idcode();
        t_codes();
        t_sample();
        t_extest();
        t_user_pins();
        report_and_stop();
    end

    // Tests need about half a millisecond
    initial
    begin
        #1_000_000;
        n_fail++;
        report_and_stop();
    end
endmodule // testbench
